//--- gpm_pin_mux.sv
// Purpose: GPIO pin mux port: 45 digital pins in two ports, 16 analog-shared pins
// Assumes: Peripheral bus with word addresses, 32-bit or 16-bit accesses
// Notes:   Read data appears one cycle after the read strobe
// Notes on behaviour
// [R1] Each pin is either software I/O or one of three peripheral signals.
// [R2] Forty-five digital pins: port A pins 0-31, port B pins 32-44.
// [R3] Every register accepts both 32-bit and 16-bit bus accesses; each interrupt select takes only one 16-bit word per access.
// [R4] Protected registers take writes only with protected-write enable high.
// [R5] Mux and qualifier selections act on the pin two cycles after the write.
// [R6] Port A first mux register: 2-bit codes for pins 0-15, 00 plain I/O.
// [R7] Port A second mux register: same 2-bit codes for pins 16-31.
// [R8] Port B mux register: 2-bit codes for pins 32-44.
// [R9] Software never picks a code with no peripheral behind it.
// [R10] Each port has a per-pin direction register.
// [R11] Each port has a per-pin pull-up disable register.
// [R12] Qualifier select: two bits per pin, registers for 0-15, 16-31, 32-44.
// [R13] Each port has a control register setting qualification sampling.
// [R14] Data register reads pin levels and writes the output latch.
// [R15] Set, clear and toggle registers follow each data register.
// [R16] Three selects each route one port A pin to an interrupt line.
// [R17] Wake-up select register marks port A pins that may wake the device.
// [R18] Analog-shared pins have a function select and a direction register.
// [R19] Analog-shared pins have data, set, clear and toggle registers.
// [R20] Qualifier 00 only synchronises; 01 and 10 use a sampling window.
// [R21] Qualifier 11 passes the input with no synchronisation.
// [R22] Window mode changes only after 3 or 6 equal samples.
// [R23] Control register sets the sampling period per group of 8 pins.
// [R24] Writing 1 sets, clears or inverts a latch bit; these read as zero.
// [R25] Direction 1 drives the pin from the latch; all pins input after reset.
`timescale 1ns/1ns
module gpm_pin_mux (
    input  wire logic          clock_i,
    input  wire logic          rst_i,
    input  wire logic          protected_write_enable_i,
    input  wire logic [15:0]   bus_addr_i,
    input  wire logic [31:0]   bus_wdata_i,
    input  wire logic          bus_wr_i,
    input  wire logic          bus_rd_i,
    input  wire logic          bus_wide_i,
    output logic      [31:0]   bus_rdata_o,
    output logic               bus_rvalid_o,
    input  wire logic [44:0]   pin_i,
    output logic      [44:0]   pin_o,
    output logic      [44:0]   pin_oe_n_o,
    output logic      [44:0]   pullup_off_o,
    input  wire logic [134:0]  periph_out_i,
    input  wire logic [134:0]  periph_drive_i,
    output logic      [44:0]   pin_in_o,
    output logic      [2:0]    ext_irq_o,
    output logic               low_power_wakeup_o,
    input  wire logic [15:0]   analog_shared_pin_i,
    output logic      [15:0]   analog_shared_pin_o,
    output logic      [15:0]   analog_shared_pin_oe_n_o,
    output logic      [15:0]   analog_mode_o,
    output logic      [15:0]   analog_pin_in_o
);
    gpm_pkg::gpm_state_t st_r;
    gpm_pkg::gpm_state_t st_nxt;

    logic [15:0] wadr;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic        pwr;
    logic [31:0] rv;
    logic [44:0] pin_lvl;

    function automatic logic [31:0] upd(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
        return (old & ~m) | (d & m);
    endfunction

    function automatic logic [31:0] bitop(input logic [31:0] old, input logic [15:0] a,
                                          input logic [15:0] base, input logic [31:0] v);
        logic [31:0] r;
        r = old;
        if (a == base) begin
            r = upd(old, wdat, wmask);
        end else if (a == base + 16'h0002) begin
            r = old | v;
        end else if (a == base + 16'h0004) begin
            r = old & ~v;
        end else if (a == base + 16'h0006) begin
            r = old ^ v;
        end
        return r;
    endfunction

    // 16-bit access at odd address hits the upper half
    assign wadr  = {bus_addr_i[15:1], 1'b0};
    assign wmask = bus_wide_i ? 32'hffffffff : (bus_addr_i[0] ? 32'hffff0000 : 32'h0000ffff); // [R3]
    assign wdat  = bus_wide_i ? bus_wdata_i : {bus_wdata_i[15:0], bus_wdata_i[15:0]};
    assign pwr   = bus_wr_i && protected_write_enable_i; // [R4]

    always_comb begin
        logic [1:0]  code;
        logic [8:0]  ld;
        logic [5:0]  tick;
        logic [5:0]  h;
        logic [31:0] t;
        code = 2'h0;
        ld   = 9'h0;
        tick = 6'h0;
        h    = 6'h0;
        t    = 32'h0;
        st_nxt = st_r;

        st_nxt.sync1  = pin_i;
        st_nxt.sync2  = st_r.sync1;
        st_nxt.async1 = analog_shared_pin_i;
        st_nxt.async2 = st_r.async1;

        // One stage after the register gives the two-cycle take-up
        st_nxt.mux_eff  = st_r.mux; // [R5]
        st_nxt.qsel_eff = st_r.qsel; // [R5]
        st_nxt.amux_eff = st_r.amux; // [R5]

        for (int g = 0; g < 6; g++) begin
            tick[g] = (st_r.cnt[9*g +: 9] == 9'h0);
            ld = {st_r.ctrl[8*g +: 8], 1'b0} - 9'h001;
            if (tick[g]) begin
                st_nxt.cnt[9*g +: 9] = (st_r.ctrl[8*g +: 8] == 8'h00) ? 9'h0 : ld; // [R23]
            end else begin
                st_nxt.cnt[9*g +: 9] = st_r.cnt[9*g +: 9] - 9'h001;
            end
        end

        for (int p = 0; p < gpm_pkg::GPM_PINS; p++) begin
            code = st_r.qsel_eff[2*p +: 2];
            h = st_r.hist[6*p +: 6];
            if (tick[p/8]) begin
                h = {h[4:0], st_r.sync2[p]};
            end
            st_nxt.hist[6*p +: 6] = h;
            case (code)
                gpm_pkg::GPM_Q_WIN3: begin
                    if (h[2:0] == 3'h0 || h[2:0] == 3'h7) begin
                        st_nxt.qual[p] = h[0]; // [R22]
                    end
                end
                gpm_pkg::GPM_Q_WIN6: begin
                    if (h == 6'h00 || h == 6'h3f) begin
                        st_nxt.qual[p] = h[0]; // [R22]
                    end
                end
                default: st_nxt.qual[p] = st_r.sync2[p]; // [R20]
            endcase
        end

        if (pwr) begin
            if (wadr == gpm_pkg::GPM_A_CTRL) begin
                st_nxt.ctrl[31:0] = upd(st_r.ctrl[31:0], wdat, wmask); // [R13]
            end else if (wadr == gpm_pkg::GPM_B_CTRL) begin
                st_nxt.ctrl[63:32] = upd(st_r.ctrl[63:32], wdat, wmask) & 32'h0000ffff; // [R13]
            end else if (wadr == gpm_pkg::GPM_A_QSEL1) begin
                st_nxt.qsel[31:0] = upd(st_r.qsel[31:0], wdat, wmask); // [R12]
            end else if (wadr == gpm_pkg::GPM_A_QSEL2) begin
                st_nxt.qsel[63:32] = upd(st_r.qsel[63:32], wdat, wmask); // [R12]
            end else if (wadr == gpm_pkg::GPM_B_QSEL) begin
                st_nxt.qsel[95:64] = upd(st_r.qsel[95:64], wdat, wmask) & gpm_pkg::GPM_QB_MASK; // [R12]
            end else if (wadr == gpm_pkg::GPM_A_MUX1) begin
                st_nxt.mux[31:0] = upd(st_r.mux[31:0], wdat, wmask); // [R6]
            end else if (wadr == gpm_pkg::GPM_A_MUX2) begin
                st_nxt.mux[63:32] = upd(st_r.mux[63:32], wdat, wmask); // [R7]
            end else if (wadr == gpm_pkg::GPM_B_MUX) begin
                st_nxt.mux[95:64] = upd(st_r.mux[95:64], wdat, wmask) & gpm_pkg::GPM_QB_MASK; // [R8]
            end else if (wadr == gpm_pkg::GPM_A_DIR) begin
                st_nxt.dir[31:0] = upd(st_r.dir[31:0], wdat, wmask); // [R10]
            end else if (wadr == gpm_pkg::GPM_B_DIR) begin
                st_nxt.dir[63:32] = upd(st_r.dir[63:32], wdat, wmask) & gpm_pkg::GPM_B_MASK; // [R10]
            end else if (wadr == gpm_pkg::GPM_A_PUD) begin
                st_nxt.pud[31:0] = upd(st_r.pud[31:0], wdat, wmask); // [R11]
            end else if (wadr == gpm_pkg::GPM_B_PUD) begin
                st_nxt.pud[63:32] = upd(st_r.pud[63:32], wdat, wmask) & gpm_pkg::GPM_B_MASK; // [R11]
            end else if (wadr == gpm_pkg::GPM_AN_MUX) begin
                st_nxt.amux = upd(st_r.amux, wdat, wmask); // [R18]
            end else if (wadr == gpm_pkg::GPM_AN_DIR) begin
                t = upd({16'h0, st_r.adir}, wdat, wmask);
                st_nxt.adir = t[15:0]; // [R18]
            end else if (wadr == gpm_pkg::GPM_WAKE_SEL) begin
                st_nxt.wake = upd(st_r.wake, wdat, wmask); // [R17]
            end

            // Interrupt selects are 16-bit words; 5 bits kept
            for (int k = 0; k < 3; k++) begin
                if (bus_addr_i == gpm_pkg::GPM_IRQ1_SEL + 16'(k)) begin
                    st_nxt.xsel[5*k +: 5] = bus_wdata_i[4:0]; // [R16]
                end
            end
        end

        if (bus_wr_i) begin
            st_nxt.lat[31:0] = bitop(st_r.lat[31:0], wadr, gpm_pkg::GPM_A_DAT, wdat & wmask); // [R14] [R15] [R24]
            st_nxt.lat[63:32] = bitop(st_r.lat[63:32], wadr, gpm_pkg::GPM_B_DAT, wdat & wmask)
                              & gpm_pkg::GPM_B_MASK; // [R15] [R24]
            t = bitop({16'h0, st_r.alat}, wadr, gpm_pkg::GPM_AN_DAT, wdat & wmask);
            st_nxt.alat = t[15:0]; // [R19]
        end

        st_nxt.rvalid = bus_rd_i;
        if (bus_rd_i) begin
            st_nxt.rdata = bus_wide_i ? rv : (bus_addr_i[0] ? {16'h0, rv[31:16]} : {16'h0, rv[15:0]}); // [R3]
        end
    end

    // Set, clear and toggle locations and unmapped addresses read zero
    always_comb begin
        rv = 32'h0;
        if (wadr == gpm_pkg::GPM_A_CTRL) begin
            rv = st_r.ctrl[31:0];
        end else if (wadr == gpm_pkg::GPM_B_CTRL) begin
            rv = st_r.ctrl[63:32];
        end else if (wadr == gpm_pkg::GPM_A_QSEL1) begin
            rv = st_r.qsel[31:0];
        end else if (wadr == gpm_pkg::GPM_A_QSEL2) begin
            rv = st_r.qsel[63:32];
        end else if (wadr == gpm_pkg::GPM_B_QSEL) begin
            rv = st_r.qsel[95:64];
        end else if (wadr == gpm_pkg::GPM_A_MUX1) begin
            rv = st_r.mux[31:0];
        end else if (wadr == gpm_pkg::GPM_A_MUX2) begin
            rv = st_r.mux[63:32];
        end else if (wadr == gpm_pkg::GPM_B_MUX) begin
            rv = st_r.mux[95:64];
        end else if (wadr == gpm_pkg::GPM_A_DIR) begin
            rv = st_r.dir[31:0];
        end else if (wadr == gpm_pkg::GPM_B_DIR) begin
            rv = st_r.dir[63:32];
        end else if (wadr == gpm_pkg::GPM_A_PUD) begin
            rv = st_r.pud[31:0];
        end else if (wadr == gpm_pkg::GPM_B_PUD) begin
            rv = st_r.pud[63:32];
        end else if (wadr == gpm_pkg::GPM_AN_MUX) begin
            rv = st_r.amux;
        end else if (wadr == gpm_pkg::GPM_AN_DIR) begin
            rv = {16'h0, st_r.adir};
        end else if (wadr == gpm_pkg::GPM_A_DAT) begin
            rv = st_r.qual[31:0]; // [R14]
        end else if (wadr == gpm_pkg::GPM_B_DAT) begin
            rv = {19'h0, st_r.qual[44:32]}; // [R14]
        end else if (wadr == gpm_pkg::GPM_AN_DAT) begin
            rv = {16'h0, st_r.async2}; // [R19]
        end else if (wadr == gpm_pkg::GPM_WAKE_SEL) begin
            rv = st_r.wake;
        end else if (bus_addr_i >= gpm_pkg::GPM_IRQ1_SEL && bus_addr_i < gpm_pkg::GPM_IRQ1_SEL + 16'h0003) begin
            rv = {27'h0, st_r.xsel[5*(bus_addr_i - gpm_pkg::GPM_IRQ1_SEL) +: 5]};
            rv = bus_addr_i[0] ? {rv[15:0], 16'h0} : rv;
        end
    end

    // Code 11 bypasses both synchroniser stages; peripherals must resync it
    always_comb begin
        logic [1:0] c;
        c = 2'h0;
        for (int p = 0; p < gpm_pkg::GPM_PINS; p++) begin
            c = st_r.qsel_eff[2*p +: 2];
            pin_lvl[p] = (c == gpm_pkg::GPM_Q_RAW) ? pin_i[p] : st_r.qual[p]; // [R21]
            c = st_r.mux_eff[2*p +: 2];
            if (c == 2'h0) begin
                pin_o[p]      = st_r.lat[p]; // [R1] [R25]
                pin_oe_n_o[p] = ~st_r.dir[p]; // [R25]
            end else begin
                // Reserved codes still drive whatever the empty slot presents
                pin_o[p]      = periph_out_i[3*p + int'(c) - 1]; // [R1] [R9]
                pin_oe_n_o[p] = ~periph_drive_i[3*p + int'(c) - 1]; // [R1]
            end
        end
    end

    assign pin_in_o = pin_lvl; // [R2]
    assign pullup_off_o = {st_r.pud[44:32], st_r.pud[31:0]}; // [R11]
    assign bus_rdata_o = st_r.rdata;
    assign bus_rvalid_o = st_r.rvalid;
    assign low_power_wakeup_o = |(st_r.wake & pin_lvl[31:0]); // [R17]

    always_comb begin
        for (int k = 0; k < 3; k++) begin
            ext_irq_o[k] = pin_lvl[st_r.xsel[5*k +: 5]]; // [R16]
        end
        for (int i = 0; i < gpm_pkg::GPM_APINS; i++) begin
            analog_mode_o[i] = st_r.amux_eff[2*i + 1]; // [R18]
            analog_shared_pin_oe_n_o[i] = ~(st_r.adir[i] & ~st_r.amux_eff[2*i + 1]); // [R18]
        end
    end
    assign analog_shared_pin_o = st_r.alat; // [R19]
    assign analog_pin_in_o = st_r.async2;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= gpm_pkg::GPM_ST_RST; // [R25]
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    property p_mux_delay;
        (pwr && bus_wide_i && bus_addr_i == gpm_pkg::GPM_A_MUX1) |-> ##2 st_r.mux_eff[31:0] == $past(bus_wdata_i, 2);
    endproperty
    a_mux_delay: assert property (p_mux_delay) else $error("mux select late"); // [R5]

    property p_protect;
        (bus_wr_i && !protected_write_enable_i && wadr == gpm_pkg::GPM_A_CTRL) |=> st_r.ctrl == $past(st_r.ctrl);
    endproperty
    a_protect: assert property (p_protect) else $error("unprotected control write took effect"); // [R4]

    property p_set;
        (bus_wr_i && bus_wide_i && wadr == gpm_pkg::GPM_A_SET) |=>
            st_r.lat[31:0] == ($past(st_r.lat[31:0]) | $past(bus_wdata_i));
    endproperty
    a_set: assert property (p_set) else $error("set register wrong"); // [R24]

    property p_input_dir;
        (st_r.mux_eff[1:0] == 2'h0) |-> (pin_oe_n_o[0] == ~st_r.dir[0]) && (pin_o[0] == st_r.lat[0]);
    endproperty
    a_input_dir: assert property (p_input_dir) else $error("pin 0 drive wrong"); // [R25]

    property p_sync;
        (!($past(rst_i) || $past(rst_i, 2) || $past(rst_i, 3)) &&
            $past(st_r.qsel_eff[1:0]) == gpm_pkg::GPM_Q_SYNC && st_r.qsel_eff[1:0] == gpm_pkg::GPM_Q_SYNC)
            |-> pin_in_o[0] == $past(pin_i[0], 3);
    endproperty
    a_sync: assert property (p_sync) else $error("sync path delay wrong"); // [R20]

    property p_window;
        ($changed(st_r.qual[0]) && $past(st_r.qsel_eff[1:0]) == gpm_pkg::GPM_Q_WIN3)
            |-> st_r.hist[2:0] == {3{st_r.qual[0]}};
    endproperty
    a_window: assert property (p_window) else $error("window changed early"); // [R22]

    property p_irq;
        ext_irq_o[1] == pin_in_o[st_r.xsel[9:5]];
    endproperty
    a_irq: assert property (p_irq) else $error("irq line two wrong pin"); // [R16]

    property p_read;
        (bus_rd_i && bus_wide_i && wadr == gpm_pkg::GPM_A_DAT) |=>
            bus_rvalid_o && bus_rdata_o == $past(st_r.qual[31:0]);
    endproperty
    a_read: assert property (p_read) else $error("data read wrong"); // [R14]

    property p_periph;
        (st_r.mux_eff[1:0] == 2'h1) |-> pin_o[0] == periph_out_i[0];
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral 1 not routed"); // [R1]

    c_periph: cover property (st_r.mux_eff[3:2] == 2'h3 && !pin_oe_n_o[1]);
    c_win6: cover property (st_r.qsel_eff[1:0] == gpm_pkg::GPM_Q_WIN6 && $changed(st_r.qual[0]));
    c_toggle: cover property (bus_wr_i && wadr == gpm_pkg::GPM_B_TOG);
    c_wake: cover property (low_power_wakeup_o);
endmodule

//--- gpm_pkg.sv
// Purpose: Constants and state layout for the GPIO pin mux port
// Assumes: Word (16-bit) addressing on the peripheral bus
// Notes:   Port B fields sit in the upper word of every 64-bit port vector
package gpm_pkg;
    localparam logic [15:0] GPM_A_CTRL   = 16'h6f80;
    localparam logic [15:0] GPM_A_QSEL1  = 16'h6f82;
    localparam logic [15:0] GPM_A_QSEL2  = 16'h6f84;
    localparam logic [15:0] GPM_A_MUX1   = 16'h6f86;
    localparam logic [15:0] GPM_A_MUX2   = 16'h6f88;
    localparam logic [15:0] GPM_A_DIR    = 16'h6f8a;
    localparam logic [15:0] GPM_A_PUD    = 16'h6f8c;
    localparam logic [15:0] GPM_B_CTRL   = 16'h6f90;
    localparam logic [15:0] GPM_B_QSEL   = 16'h6f92;
    localparam logic [15:0] GPM_B_MUX    = 16'h6f96;
    localparam logic [15:0] GPM_B_DIR    = 16'h6f9a;
    localparam logic [15:0] GPM_B_PUD    = 16'h6f9c;
    localparam logic [15:0] GPM_AN_MUX   = 16'h6fb6;
    localparam logic [15:0] GPM_AN_DIR   = 16'h6fba;
    localparam logic [15:0] GPM_A_DAT    = 16'h6fc0;
    localparam logic [15:0] GPM_A_SET    = 16'h6fc2;
    localparam logic [15:0] GPM_A_CLR    = 16'h6fc4;
    localparam logic [15:0] GPM_A_TOG    = 16'h6fc6;
    localparam logic [15:0] GPM_B_DAT    = 16'h6fc8;
    localparam logic [15:0] GPM_B_SET    = 16'h6fca;
    localparam logic [15:0] GPM_B_CLR    = 16'h6fcc;
    localparam logic [15:0] GPM_B_TOG    = 16'h6fce;
    localparam logic [15:0] GPM_AN_DAT   = 16'h6fd8;
    localparam logic [15:0] GPM_AN_SET   = 16'h6fda;
    localparam logic [15:0] GPM_AN_CLR   = 16'h6fdc;
    localparam logic [15:0] GPM_AN_TOG   = 16'h6fde;
    localparam logic [15:0] GPM_IRQ1_SEL = 16'h6fe0;
    localparam logic [15:0] GPM_WAKE_SEL = 16'h6fe8;
    localparam logic [31:0] GPM_B_MASK   = 32'h00001fff;
    localparam logic [31:0] GPM_QB_MASK  = 32'h03ffffff;
    localparam int          GPM_PINS     = 45;
    localparam int          GPM_APINS    = 16;

    localparam logic [1:0] GPM_Q_SYNC = 2'h0;
    localparam logic [1:0] GPM_Q_WIN3 = 2'h1;
    localparam logic [1:0] GPM_Q_WIN6 = 2'h2;
    localparam logic [1:0] GPM_Q_RAW  = 2'h3;

    typedef struct packed {
        logic [63:0]  ctrl;
        logic [95:0]  qsel;
        logic [95:0]  mux;
        logic [95:0]  qsel_eff;
        logic [95:0]  mux_eff;
        logic [63:0]  dir;
        logic [63:0]  pud;
        logic [63:0]  lat;
        logic [44:0]  sync1;
        logic [44:0]  sync2;
        logic [44:0]  qual;
        logic [269:0] hist;
        logic [53:0]  cnt;
        logic [31:0]  amux;
        logic [31:0]  amux_eff;
        logic [15:0]  adir;
        logic [15:0]  alat;
        logic [15:0]  async1;
        logic [15:0]  async2;
        logic [14:0]  xsel;
        logic [31:0]  wake;
        logic [31:0]  rdata;
        logic         rvalid;
    } gpm_state_t;

    localparam gpm_state_t GPM_ST_RST = '0;
endpackage

//--- gpm_board_model.sv
// Purpose: Pads and board side facing the pin mux port
// Assumes: Undriven pads with the pull-up on read high
// Notes:   Floating pads flicker every cycle so a stale level never passes for a match
`timescale 1ns/1ns
module gpm_board_model (
    input  wire logic        clock_i,
    input  wire logic [44:0] pin_o,
    input  wire logic [44:0] pin_oe_n_o,
    input  wire logic [44:0] pullup_off_o,
    input  wire logic        ext_en_i,
    input  wire logic [44:0] ext_val_i,
    input  wire logic [15:0] an_o,
    input  wire logic [15:0] an_oe_n,
    output logic      [44:0] pin_i,
    output logic      [15:0] an_i
);
    logic [44:0] flick_r = 45'h0aaaaaaaaaaa;

    always @(posedge clock_i) flick_r <= ~flick_r;

    always_comb begin
        for (int b = 0; b < 45; b++) begin
            if (!pin_oe_n_o[b]) pin_i[b] = pin_o[b];
            else if (ext_en_i) pin_i[b] = ext_val_i[b];
            else pin_i[b] = pullup_off_o[b] ? flick_r[b] : 1'b1;
        end
        for (int b = 0; b < 16; b++) begin
            if (!an_oe_n[b]) an_i[b] = an_o[b];
            else an_i[b] = ext_en_i ? ext_val_i[b] : flick_r[b];
        end
    end
endmodule

//--- tb_gpio_pin_mux_port.sv
// Purpose: Self-checking bench for the pin mux port
// Assumes: Every peripheral slot, reserved ones too, has a live driver
// Notes:   Reset again between register sweep and pin tests
`timescale 1ns/1ns
module tb_gpio_pin_mux_port;
    logic          clock_i = 1'b0;
    logic          rst_i = 1'b1;
    logic          pwe = 1'b0;
    logic          wr = 1'b0;
    logic          rd = 1'b0;
    logic          wide = 1'b0;
    logic          ext_en = 1'b0;
    logic [15:0]   addr = '0;
    logic [31:0]   wdata = '0;
    logic [44:0]   ext_val = '0;
    logic [134:0]  pout = '0;
    logic [134:0]  pdrv = '0;
    logic [31:0]   seed = 32'h10b515d1;
    logic [31:0]   rdata;
    logic          rvalid;
    logic          wake;
    logic [2:0]    irq;
    logic [44:0]   pin_i, pin_o, oe_n, pu_off, pin_in;
    logic [15:0]   an_i, an_o, an_oe_n, an_mode, an_in;
    logic [31:0]   mem [256];
    logic [31:0]   lat [3];
    int            err_total = 0;
    int            compares = 0;
    logic [15:0]   regs [19] = '{16'h6f80, 16'h6f82, 16'h6f84, 16'h6f86, 16'h6f88, 16'h6f8a, 16'h6f8c, 16'h6f90,
        16'h6f92, 16'h6f96, 16'h6f9a, 16'h6f9c, 16'h6fb6, 16'h6fba, 16'h6fe8, 16'h6fe0, 16'h6fe1, 16'h6fe2, 16'h6f8e};

    always #5 clock_i = ~clock_i;

    gpm_pin_mux i_dut (.clock_i(clock_i), .rst_i(rst_i), .protected_write_enable_i(pwe), .bus_addr_i(addr),
        .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd), .bus_wide_i(wide), .bus_rdata_o(rdata),
        .bus_rvalid_o(rvalid), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .pullup_off_o(pu_off),
        .periph_out_i(pout), .periph_drive_i(pdrv), .pin_in_o(pin_in), .ext_irq_o(irq),
        .low_power_wakeup_o(wake), .analog_shared_pin_i(an_i), .analog_shared_pin_o(an_o),
        .analog_shared_pin_oe_n_o(an_oe_n), .analog_mode_o(an_mode), .analog_pin_in_o(an_in));

    gpm_board_model i_board (.clock_i(clock_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .pullup_off_o(pu_off),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .an_o(an_o), .an_oe_n(an_oe_n), .pin_i(pin_i), .an_i(an_i));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    always @(posedge clock_i) begin
        pout <= {pout[102:0], rnd()};
        pdrv <= {pdrv[102:0], rnd()};
    end

    function automatic logic [31:0] wmask(logic [15:0] a);
        case (a)
            16'h6f90, 16'h6fba: return 32'h0000ffff;
            16'h6f92, 16'h6f96: return gpm_pkg::GPM_QB_MASK;
            16'h6f9a, 16'h6f9c: return gpm_pkg::GPM_B_MASK;
            16'h6fe0, 16'h6fe1, 16'h6fe2: return 32'h0000001f;
            16'h6f8e: return 32'h00000000;
            default: return 32'hffffffff;
        endcase
    endfunction

    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(logic [15:0] a, logic [31:0] d, logic w, logic p);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wide <= w;
        pwe <= p;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(logic [15:0] a, logic w, logic [31:0] exp);
        @(posedge clock_i);
        addr <= a;
        wide <= w;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        chk("read valid", 64'h1, rvalid);
        chk("read data", exp, rdata);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        mem = '{default: '0};
        lat = '{default: '0};
        #1;
        chk("oe_n after reset", {45{1'b1}}, oe_n);
        chk("pullup after reset", 64'h0, pu_off);
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #300000;
        err_total++;
        $display("[ERR] watchdog expected done seen hang");
        wrap_up();
    end

    initial begin
        logic [15:0] a;
        logic [31:0] d, r, m, dd, wm, ev;
        logic [44:0] lv;
        logic        w, hi, sm;
        int          j, k, p, n, s [3];
        do_reset();
        for (int i = 0; i < 38; i++) begin
            a = regs[i % 19];
            d = rnd();
            r = rnd();
            sm = a inside {16'h6fe0, 16'h6fe1, 16'h6fe2};
            w = !sm && r[0];
            hi = !sm && !w && r[1];
            m = wmask(a) & (w ? 32'hffffffff : (hi ? 32'hffff0000 : 32'h0000ffff));
            dd = w ? d : (hi ? {d[15:0], 16'h0} : {16'h0, d[15:0]});
            bus_wr(a | {15'h0, hi}, d, w, r[2] | r[3]);
            if (r[2] | r[3]) mem[a[7:0]] = (mem[a[7:0]] & ~m) | (dd & m);
            hi = !sm && r[4];
            rd_chk(a | {15'h0, hi}, !sm && !hi, hi ? mem[a[7:0]] >> 16 : mem[a[7:0]]);
        end
        chk("pullup out", {mem[8'h9c][12:0], mem[8'h8c]}, pu_off);
        $display("test registers done");
        do_reset();
        bus_wr(16'h6f8a, 32'hffffffff, 1'b1, 1'b1);
        bus_wr(16'h6f9a, 32'h00001fff, 1'b1, 1'b1);
        bus_wr(16'h6fba, 32'h0000ffff, 1'b1, 1'b1);
        for (int i = 0; i < 24; i++) begin
            j = rnd() % 3;
            k = rnd() % 4;
            d = rnd() & (j == 0 ? 32'hffffffff : (j == 1 ? gpm_pkg::GPM_B_MASK : 32'h0000ffff));
            a = j == 0 ? 16'h6fc0 : (j == 1 ? 16'h6fc8 : 16'h6fd8);
            bus_wr(a + 16'(2 * k), d, 1'b1, rnd() % 2);
            case (k)
                0: lat[j] = d;
                1: lat[j] = lat[j] | d;
                2: lat[j] = lat[j] & ~d;
                default: lat[j] = lat[j] ^ d;
            endcase
            repeat (4) @(posedge clock_i);
            #1;
            chk("pin out", {lat[1][12:0], lat[0]}, pin_o);
            chk("analog out", lat[2], an_o);
            rd_chk(a, 1'b1, lat[j]);
            rd_chk(a + 16'(2 + 2 * (k % 3)), 1'b1, 32'h0);
        end
        $display("test latch done");
        for (int i = 0; i < 8; i++) begin
            p = rnd() % 45;
            k = 1 + rnd() % 3;
            a = p < 16 ? 16'h6f86 : (p < 32 ? 16'h6f88 : 16'h6f96);
            lv = {lat[1][12:0], lat[0]};
            bus_wr(a, 32'(k) << (2 * (p % 16)), 1'b1, 1'b1);
            #1;
            chk("mux early", lv[p], pin_o[p]);
            @(posedge clock_i);
            #1;
            chk("mux out", pout[3 * p + k - 1], pin_o[p]);
            chk("mux drive", !pdrv[3 * p + k - 1], oe_n[p]);
            bus_wr(a, 32'h0, 1'b1, 1'b1);
        end
        $display("test mux done");
        bus_wr(16'h6f8a, 32'h0, 1'b1, 1'b1);
        ext_en <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            bus_wr(16'h6f82, 32'(c), 1'b1, 1'b1);
            repeat (10) @(posedge clock_i);
            ext_val[0] <= 1'b1;
            if (c == 0) begin
                repeat (2) @(posedge clock_i);
                #1;
                chk("sync early", 64'h0, pin_in[0]);
                @(posedge clock_i);
                #1;
                chk("sync late", 64'h1, pin_in[0]);
            end else if (c == 3) begin
                #1;
                chk("raw", 64'h1, pin_in[0]);
            end else begin
                n = 3 * c;
                repeat (n - 1) @(posedge clock_i);
                ext_val[0] <= 1'b0;
                repeat (12) @(posedge clock_i);
                #1;
                chk("window glitch", 64'h0, pin_in[0]);
                @(posedge clock_i);
                ext_val[0] <= 1'b1;
                repeat (n + 6) @(posedge clock_i);
                #1;
                chk("window steady", 64'h1, pin_in[0]);
            end
            @(posedge clock_i);
            ext_val[0] <= 1'b0;
            repeat (12) @(posedge clock_i);
        end
        $display("test qualifier done");
        for (int i = 0; i < 4; i++) begin
            for (int q = 0; q < 3; q++) s[q] = 1 + rnd() % 31;
            for (int q = 0; q < 3; q++) bus_wr(16'h6fe0 + 16'(q), 32'(s[q]), 1'b0, 1'b1);
            wm = rnd() & 32'hfffffffe;
            ev = rnd() & 32'hfffffffe;
            bus_wr(16'h6fe8, wm, 1'b1, 1'b1);
            ext_val <= {13'h0, ev};
            repeat (6) @(posedge clock_i);
            #1;
            chk("irq lines", {ev[s[2]], ev[s[1]], ev[s[0]]}, irq);
            chk("wakeup", |(wm & ev), wake);
        end
        $display("test irq and wake done");
        wrap_up();
    end
endmodule
